// file: verilog/obc_config_regs.sv
// Oscillator and brown-out configuration register bank.
`timescale 1ns/1ps
`include "obc_map.svh"
module obc_config_regs (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Peripheral bus access.
  input wire logic pbSel,
  input wire logic pbWrite,
  input wire obc_pkg::obc_addr_t pbAddr,
  input wire obc_pkg::obc_word_t pbWdata,
  output obc_pkg::obc_word_t pbRdata,
  output logic pbReady,
  // Fuse values from the flash controller.
  input wire logic fuseReady,
  input wire logic [9:0] fuseCoreBod,
  input wire logic [2:0] fuseBandgap,
  input wire logic [9:0] fuseIoBod,
  // Reset cause and brown-out sense.
  input wire logic warmResetReq,
  input wire logic resetByCoreBod,
  input wire logic coreBodDetect,
  input wire logic coreBodIrqMask,
  input wire logic slowRcClk,
  // Oscillator controls.
  output logic [1:0] oscEnable,
  output logic [1:0] oscCrystalEnable,
  output logic [1:0] oscOutPinFree,
  output logic [1:0] oscAutoGain,
  output logic [3:0] oscGain,
  output logic [1:0] oscReady,
  // Brown-out and bandgap controls.
  output logic [1:0] coreBodCtrl,
  output logic coreBodHyst,
  output logic [5:0] coreBodLevel,
  output logic coreBodResetReq,
  output logic coreBodIrq,
  output logic [1:0] ioBodCtrl,
  output logic ioBodHyst,
  output logic [5:0] ioBodLevel,
  output logic [2:0] bandgapTrim
);
  import obc_pkg::*;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [2:0] rcSync_reg;
  logic [2:0] warmSync_reg;
  logic [1:0] causeSync_reg;
  logic [1:0] detSync_reg;
  logic rcTick;
  logic warmEvent;

  // Pins cross in two flops; the third flop only feeds edge detection.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rcSync_reg <= 3'h0;
      warmSync_reg <= 3'h0;
      causeSync_reg <= 2'h0;
      detSync_reg <= 2'h0;
    end else begin
      rcSync_reg <= {rcSync_reg[1:0], slowRcClk};
      warmSync_reg <= {warmSync_reg[1:0], warmResetReq};
      causeSync_reg <= {causeSync_reg[0], resetByCoreBod};
      detSync_reg <= {detSync_reg[0], coreBodDetect};
    end
  end
  assign rcTick = rcSync_reg[1] && !rcSync_reg[2];
  assign warmEvent = warmSync_reg[1] && !warmSync_reg[2];

  // ------------------------------------------------------------
  // Bus decode and unlock
  // ------------------------------------------------------------
  logic wrAcc;
  logic unlockHit;
  logic protOk;
  logic unlockValid_reg;
  obc_addr_t unlockAddr_reg;

  assign wrAcc = pbSel && pbWrite;
  assign unlockHit = wrAcc && pbAddr == `OBC_UNLOCK_OFS &&
    pbWdata[`OBC_KEY_HI:`OBC_KEY_LO] == `OBC_KEY;
  assign protOk = unlockValid_reg && unlockAddr_reg == pbAddr;

  // Any access consumes the unlock, so a stray read also relocks.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unlockValid_reg <= 1'b0;
      unlockAddr_reg <= 10'h000;
    end else if (pbSel) begin
      unlockValid_reg <= unlockHit;
      if (unlockHit) begin
        unlockAddr_reg <= pbWdata[`OBC_ADDR_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Fuse loader
  // ------------------------------------------------------------
  obc_fuse_state_t fuseState_reg;
  logic [2:0] reload_reg;
  logic fuseLoad;
  obc_word_t coreBod_reg;
  obc_word_t bandgap_reg;
  obc_word_t ioBod_reg;

  assign fuseLoad = fuseState_reg == OBC_FL_WAIT && fuseReady;

  // A warm reset caused by a core brown-out keeps calibrated fields.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fuseState_reg <= OBC_FL_WAIT;
      reload_reg <= 3'h7;
    end else begin
      unique case (fuseState_reg)
        OBC_FL_IDLE: begin
          if (warmEvent) begin
            fuseState_reg <= OBC_FL_WAIT;
            reload_reg <= {!ioBod_reg[`OBC_FCD_BIT] || !causeSync_reg[1],
              !bandgap_reg[`OBC_FCD_BIT] || !causeSync_reg[1],
              !coreBod_reg[`OBC_FCD_BIT] || !causeSync_reg[1]};
          end
        end
        OBC_FL_WAIT: begin
          if (fuseReady) begin
            fuseState_reg <= OBC_FL_IDLE;
            reload_reg <= 3'h0;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Protected registers
  // ------------------------------------------------------------
  logic wrCore;
  logic wrBg;
  logic wrIo;
  obc_word_t oscCtrl_reg [2];

  assign wrCore = wrAcc && protOk && pbAddr == `OBC_BOD_OFS &&
    !coreBod_reg[`OBC_SFV_BIT];
  assign wrBg = wrAcc && protOk && pbAddr == `OBC_BG_OFS &&
    !bandgap_reg[`OBC_SFV_BIT];
  assign wrIo = wrAcc && protOk && pbAddr == `OBC_IO_BROWNOUT_CONTROL_OFS &&
    !ioBod_reg[`OBC_SFV_BIT];

  // Fuse load wins over software; the done flag is hardware owned.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coreBod_reg <= 32'h00000000;
    end else if (fuseLoad && reload_reg[0]) begin
      coreBod_reg <= ({22'h000000, fuseCoreBod} & `OBC_BOD_MASK) |
        `OBC_FCD_MASK;
    end else if (wrCore) begin
      coreBod_reg <= (pbWdata & `OBC_BOD_MASK) |
        (coreBod_reg & `OBC_FCD_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bandgap_reg <= 32'h00000000;
    end else if (fuseLoad && reload_reg[1]) begin
      bandgap_reg <= {29'h00000000, fuseBandgap} | `OBC_FCD_MASK;
    end else if (wrBg) begin
      bandgap_reg <= (pbWdata & `OBC_BG_MASK) |
        (bandgap_reg & `OBC_FCD_MASK);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ioBod_reg <= 32'h00000000;
    end else if (fuseLoad && reload_reg[2]) begin
      ioBod_reg <= ({22'h000000, fuseIoBod} & `OBC_BOD_MASK) |
        `OBC_FCD_MASK;
    end else if (wrIo) begin
      ioBod_reg <= (pbWdata & `OBC_BOD_MASK) |
        (ioBod_reg & `OBC_FCD_MASK);
    end
  end

  // ------------------------------------------------------------
  // Oscillator channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_osc
    localparam obc_addr_t OFS = 10'(`OBC_OSC0_OFS + `OBC_OSC_STRIDE * i);
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        oscCtrl_reg[i] <= 32'h00000000;
      end else if (wrAcc && protOk && pbAddr == OFS) begin
        oscCtrl_reg[i] <= pbWdata & `OBC_OSC_MASK;
      end
    end
    assign oscEnable[i] = oscCtrl_reg[i][`OBC_OSCEN_BIT];
    assign oscCrystalEnable[i] = oscCtrl_reg[i][`OBC_MODE_BIT];
    assign oscAutoGain[i] = oscCtrl_reg[i][`OBC_AGC_BIT];
    assign oscGain[2*i+1:2*i] = oscCtrl_reg[i][`OBC_GAIN_HI:`OBC_GAIN_LO];
    // The pin flag is a flop of its own so the output stays registered.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        oscOutPinFree[i] <= 1'b1;
      end else begin
        oscOutPinFree[i] <= !oscCtrl_reg[i][`OBC_MODE_BIT];
      end
    end
    obc_startup_counter u_start (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .enable(oscCtrl_reg[i][`OBC_OSCEN_BIT]),
      .code(oscCtrl_reg[i][`OBC_SU_HI:`OBC_SU_LO]),
      .rcTick(rcTick),
      .ready(oscReady[i])
    );
  end

  // ------------------------------------------------------------
  // Analog controls and brown-out responses
  // ------------------------------------------------------------
  assign coreBodCtrl = coreBod_reg[`OBC_CTRL_HI:`OBC_CTRL_LO];
  assign coreBodHyst = coreBod_reg[`OBC_HYSTERESIS_ENABLE_BIT];
  assign coreBodLevel = coreBod_reg[`OBC_LVL_HI:`OBC_LVL_LO];
  assign ioBodCtrl = ioBod_reg[`OBC_CTRL_HI:`OBC_CTRL_LO];
  assign ioBodHyst = ioBod_reg[`OBC_HYSTERESIS_ENABLE_BIT];
  assign ioBodLevel = ioBod_reg[`OBC_LVL_HI:`OBC_LVL_LO];
  assign bandgapTrim = bandgap_reg[`OBC_TRIM_HI:`OBC_TRIM_LO];

  // Reserved control code 3 acts as off, so it can neither reset nor alert.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coreBodResetReq <= 1'b0;
      coreBodIrq <= 1'b0;
    end else begin
      coreBodResetReq <= detSync_reg[1] &&
        coreBodCtrl == `OBC_CTRL_RESET;
      coreBodIrq <= detSync_reg[1] && coreBodIrqMask &&
        coreBodCtrl == `OBC_CTRL_IRQ;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pbRdata <= 32'h00000000;
      pbReady <= 1'b0;
    end else begin
      pbReady <= pbSel;
      if (pbSel && !pbWrite) begin
        unique case (pbAddr)
          `OBC_OSC0_OFS: pbRdata <= oscCtrl_reg[0];
          `OBC_OSC0_OFS + `OBC_OSC_STRIDE: pbRdata <= oscCtrl_reg[1];
          `OBC_BOD_OFS: pbRdata <= coreBod_reg;
          `OBC_BG_OFS: pbRdata <= bandgap_reg;
          `OBC_IO_BROWNOUT_CONTROL_OFS: pbRdata <= ioBod_reg;
          default: pbRdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_unlock;
    unlockHit;
  endsequence
  property p_unlockArm;
    s_unlock |=> unlockValid_reg && unlockAddr_reg == $past(pbWdata[9:0]);
  endproperty
  a_unlockArm: assert property (p_unlockArm)
    else $error("Unlock did not arm for the given address.");

  property p_unlockOnce;
    unlockValid_reg && pbSel && !unlockHit |=> !unlockValid_reg;
  endproperty
  a_unlockOnce: assert property (p_unlockOnce)
    else $error("Unlock survived a following access.");

  property p_lockedCore;
    wrAcc && pbAddr == `OBC_BOD_OFS && !protOk && !fuseLoad
      |=> $stable(coreBod_reg);
  endproperty
  a_lockedCore: assert property (p_lockedCore)
    else $error("Locked write changed the core brown-out register.");

  property p_finalBg;
    bandgap_reg[`OBC_SFV_BIT] && !fuseLoad |=> $stable(bandgap_reg);
  endproperty
  a_finalBg: assert property (p_finalBg)
    else $error("Final bandgap register changed.");

  property p_coreDone;
    fuseLoad && reload_reg[0] |=> coreBod_reg[`OBC_FCD_BIT] &&
      coreBod_reg[9:0] == ($past(fuseCoreBod) & 10'h37f);
  endproperty
  a_coreDone: assert property (p_coreDone)
    else $error("Core fuse load did not complete.");

  property p_bgDone;
    fuseLoad && reload_reg[1] |=> bandgap_reg[`OBC_FCD_BIT];
  endproperty
  a_bgDone: assert property (p_bgDone)
    else $error("Bandgap done flag not set after load.");

  property p_skipReload;
    fuseState_reg == OBC_FL_IDLE && warmEvent && causeSync_reg[1] &&
      coreBod_reg[`OBC_FCD_BIT] |=> !reload_reg[0];
  endproperty
  a_skipReload: assert property (p_skipReload)
    else $error("Calibrated core register reloaded after brown-out.");

  property p_resetReq;
    coreBodResetReq |-> $past(coreBodCtrl) == `OBC_CTRL_RESET &&
      $past(detSync_reg[1]);
  endproperty
  a_resetReq: assert property (p_resetReq)
    else $error("Reset request without reset mode.");

  property p_irqOnly;
    detSync_reg[1] && coreBodCtrl == `OBC_CTRL_IRQ
      |=> !coreBodResetReq && coreBodIrq == $past(coreBodIrqMask);
  endproperty
  a_irqOnly: assert property (p_irqOnly)
    else $error("Interrupt mode response is wrong.");
endmodule

// file: verilog/obc_map.svh
// Register map, field positions and constants of the config register bank.
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH
`define OBC_ADDR_W 10
`define OBC_UNLOCK_OFS 10'h018
`define OBC_OSC0_OFS 10'h024
`define OBC_OSC_STRIDE 10'h004
`define OBC_BOD_OFS 10'h02c
`define OBC_BG_OFS 10'h030
`define OBC_IO_BROWNOUT_CONTROL_OFS 10'h034
`define OBC_KEY 8'haa
`define OBC_KEY_HI 31
`define OBC_KEY_LO 24
`define OBC_SFV_BIT 31
`define OBC_FCD_BIT 16
`define OBC_OSCEN_BIT 16
`define OBC_AGC_BIT 3
`define OBC_MODE_BIT 0
`define OBC_GAIN_HI 2
`define OBC_GAIN_LO 1
`define OBC_SU_HI 11
`define OBC_SU_LO 8
`define OBC_CTRL_HI 9
`define OBC_CTRL_LO 8
`define OBC_HYSTERESIS_ENABLE_BIT 6
`define OBC_LVL_HI 5
`define OBC_LVL_LO 0
`define OBC_TRIM_HI 2
`define OBC_TRIM_LO 0
`define OBC_OSC_MASK 32'h00010f0f
`define OBC_BOD_MASK 32'h8000037f
`define OBC_BG_MASK 32'h80000007
`define OBC_FCD_MASK 32'h00010000
`define OBC_CTRL_OFF 2'h0
`define OBC_CTRL_RESET 2'h1
`define OBC_CTRL_IRQ 2'h2
`define OBC_CNT_W 16
`endif

// file: verilog/obc_pkg.sv
// Types shared by the config register bank.
package obc_pkg;
  typedef logic [31:0] obc_word_t;
  typedef logic [9:0] obc_addr_t;
  typedef enum logic {OBC_FL_IDLE, OBC_FL_WAIT} obc_fuse_state_t;
endpackage

// file: verilog/obc_startup_counter.sv
// Oscillator startup counter advanced by slow RC ticks.
`timescale 1ns/1ps
`include "obc_map.svh"
module obc_startup_counter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Control.
  input wire logic enable,
  input wire logic [3:0] code,
  input wire logic rcTick,
  // Status.
  output logic ready
);
  import obc_pkg::*;

  logic [`OBC_CNT_W-1:0] count_reg;
  logic [`OBC_CNT_W-1:0] target;
  logic [`OBC_CNT_W-1:0] countNext;

  // Decode of the startup code; reserved code 15 waits the longest.
  always_comb begin
    unique case (code)
      4'h0: target = 16'h0000;
      4'h1: target = 16'h0040;
      4'h2: target = 16'h0080;
      4'h3: target = 16'h0800;
      4'h4: target = 16'h1000;
      4'h5: target = 16'h2000;
      4'h6: target = 16'h4000;
      4'h7: target = 16'h8000;
      4'h8: target = 16'h0004;
      4'h9: target = 16'h0008;
      4'ha: target = 16'h0010;
      4'hb: target = 16'h0020;
      4'hc: target = 16'h0100;
      4'hd: target = 16'h0200;
      4'he: target = 16'h0400;
      default: target = 16'h8000;
    endcase
  end

  assign countNext = count_reg + 16'h0001;

  // Dropping enable restarts the wait from zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 16'h0000;
      ready <= 1'b0;
    end else if (!enable) begin
      count_reg <= 16'h0000;
      ready <= 1'b0;
    end else if (!ready) begin
      if (target == 16'h0000) begin
        ready <= 1'b1;
      end else if (rcTick) begin
        count_reg <= countNext;
        ready <= (countNext >= target);
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_readyCause;
    $rose(ready) |-> $past(enable) && ($past(rcTick) || $past(code) == 4'h0);
  endproperty
  a_readyCause: assert property (p_readyCause)
    else $error("Ready rose without a slow RC tick.");
endmodule

// file: bench/obc_config_regs_test.sv
// Self-checking testbench of the oscillator and brown-out register bank.
`timescale 1ns/1ps
`include "obc_map.svh"
module obc_config_regs_test;
  import obc_pkg::*;
  // ----------------------------------------
  // Design inputs and outputs
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic pbSel = 1'b0;
  logic pbWrite = 1'b0;
  obc_addr_t pbAddr = '0;
  obc_word_t pbWdata = '0;
  obc_word_t pbRdata;
  logic pbReady;
  logic fuseReady = 1'b0;
  logic [9:0] fuseCoreBod = 10'h145;
  logic [2:0] fuseBandgap = 3'h5;
  logic [9:0] fuseIoBod = 10'h24a;
  logic warmResetReq = 1'b0;
  logic resetByCoreBod = 1'b0;
  logic coreBodDetect = 1'b0;
  logic coreBodIrqMask = 1'b0;
  logic slowRcClk = 1'b0;
  logic [1:0] oscEnable, oscCrystalEnable, oscOutPinFree, oscAutoGain;
  logic [3:0] oscGain;
  logic [1:0] oscReady, coreBodCtrl, ioBodCtrl;
  logic coreBodHyst, coreBodResetReq, coreBodIrq, ioBodHyst;
  logic [5:0] coreBodLevel, ioBodLevel;
  logic [2:0] bandgapTrim;
  int failCount = 0;
  int checked = 0;

  obc_config_regs i_obc_config_regs (
    .ref_clk(ref_clk), .nrst(nrst),
    .pbSel(pbSel), .pbWrite(pbWrite), .pbAddr(pbAddr),
    .pbWdata(pbWdata), .pbRdata(pbRdata), .pbReady(pbReady),
    .fuseReady(fuseReady), .fuseCoreBod(fuseCoreBod),
    .fuseBandgap(fuseBandgap), .fuseIoBod(fuseIoBod),
    .warmResetReq(warmResetReq), .resetByCoreBod(resetByCoreBod),
    .coreBodDetect(coreBodDetect), .coreBodIrqMask(coreBodIrqMask),
    .slowRcClk(slowRcClk),
    .oscEnable(oscEnable), .oscCrystalEnable(oscCrystalEnable),
    .oscOutPinFree(oscOutPinFree), .oscAutoGain(oscAutoGain),
    .oscGain(oscGain), .oscReady(oscReady),
    .coreBodCtrl(coreBodCtrl), .coreBodHyst(coreBodHyst),
    .coreBodLevel(coreBodLevel), .coreBodResetReq(coreBodResetReq),
    .coreBodIrq(coreBodIrq), .ioBodCtrl(ioBodCtrl),
    .ioBodHyst(ioBodHyst), .ioBodLevel(ioBodLevel),
    .bandgapTrim(bandgapTrim)
  );

  // 25 MHz clock, 40 ns period.
  always begin
    #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count; four-state compare so an unknown never matches.
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ends the run; shared by the main sequence and the watchdog.
  task automatic tally_and_finish();
    if (failCount == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One bus access, entered 1 ns after an edge; pbSel is up for one edge.
  task automatic access(input logic wr, input obc_addr_t a,
                        input obc_word_t d, output obc_word_t q);
    int n;
    n = 0;
    pbSel = 1'b1;
    pbWrite = wr;
    pbAddr = a;
    pbWdata = d;
    @(posedge ref_clk);
    #1;
    pbSel = 1'b0;
    while (pbReady !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("ready", 32'(pbReady), 32'h1);
    q = pbRdata;
    // One idle edge, so the next call never re-raises pbSel in the same
    // time step, and the one-cycle ready pulse is seen to end.
    @(posedge ref_clk);
    #1;
    check("readyLow", 32'(pbReady), 32'h0);
  endtask

  task automatic wr(input obc_addr_t a, input obc_word_t d);
    obc_word_t q;
    access(1'b1, a, d, q);
  endtask

  // Key and address write, then the protected write right after it.
  task automatic unl_wr(input obc_addr_t a, input obc_word_t d);
    wr(`OBC_UNLOCK_OFS, {`OBC_KEY, 14'h0, a});
    wr(a, d);
  endtask

  task automatic rd(input string nm, input obc_addr_t a,
                    input obc_word_t exp);
    obc_word_t q;
    access(1'b0, a, '0, q);
    check(nm, q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // n slow RC ticks, each held long enough to cross the two-flop sync.
  task automatic tick(input int n);
    repeat (n) begin
      slowRcClk = 1'b1;
      cyc(4);
      slowRcClk = 1'b0;
      cyc(4);
    end
  endtask

  // Warm reset with a chosen cause, followed by a fuse delivery.
  task automatic warm(input logic byBod);
    resetByCoreBod = byBod;
    warmResetReq = 1'b1;
    cyc(6);
    fuseReady = 1'b1;
    cyc(1);
    fuseReady = 1'b0;
    warmResetReq = 1'b0;
    cyc(4);
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Tests take under 1000 cycles; a hang is cut at 5000.
  initial begin
    repeat (5000) @(posedge ref_clk);
    failCount++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(4);
    nrst = 1'b1;
    check("pinFree", 32'(oscOutPinFree), 32'h3);
    rd("bodRst", `OBC_BOD_OFS, 32'h0);
    rd("bgRst", `OBC_BG_OFS, 32'h0);
    rd("ioRst", `OBC_IO_BROWNOUT_CONTROL_OFS, 32'h0);
    rd("unlockRd", `OBC_UNLOCK_OFS, 32'h0);
    rd("unmapped", 10'h3f0, 32'h0);
    // Locked write, then unlocked one; it sets control 2 and level 1.
    wr(`OBC_BOD_OFS, 32'h00000201);
    rd("locked", `OBC_BOD_OFS, 32'h0);
    unl_wr(`OBC_BOD_OFS, 32'h00000201);
    rd("unlocked", `OBC_BOD_OFS, 32'h00000201);
    check("ctrl", 32'(coreBodCtrl), 32'h2);
    check("level", 32'(coreBodLevel), 32'h1);
    // An access between key and target relocks.
    wr(`OBC_UNLOCK_OFS, {`OBC_KEY, 14'h0, `OBC_BOD_OFS});
    rd("between", `OBC_BG_OFS, 32'h0);
    wr(`OBC_BOD_OFS, 32'h0);
    rd("relock", `OBC_BOD_OFS, 32'h00000201);
    wr(`OBC_UNLOCK_OFS, {8'h55, 14'h0, `OBC_BOD_OFS});
    wr(`OBC_BOD_OFS, 32'h0);
    rd("badKey", `OBC_BOD_OFS, 32'h00000201);
    // Fuse delivery loads all three registers and sets the done flags.
    fuseReady = 1'b1;
    cyc(1);
    fuseReady = 1'b0;
    cyc(1);
    rd("bodFuse", `OBC_BOD_OFS, 32'h00010145);
    rd("bgFuse", `OBC_BG_OFS, 32'h00010005);
    rd("ioFuse", `OBC_IO_BROWNOUT_CONTROL_OFS, 32'h0001024a);
    check("trim", 32'(bandgapTrim), 32'h5);
    check("hysteresis_enable", 32'(coreBodHyst), 32'h1);
    check("ioLvl", 32'({ioBodCtrl, ioBodHyst, ioBodLevel}), 32'h14a);
    // Control mode 1 resets on detection.
    coreBodDetect = 1'b1;
    cyc(5);
    check("rst1", 32'(coreBodResetReq), 32'h1);
    check("irq1", 32'(coreBodIrq), 32'h0);
    coreBodDetect = 1'b0;
    cyc(5);
    // Mode 2 only interrupts, and only when unmasked; done flag stays.
    unl_wr(`OBC_BOD_OFS, 32'h00000245);
    rd("fcdKept", `OBC_BOD_OFS, 32'h00010245);
    coreBodIrqMask = 1'b1;
    coreBodDetect = 1'b1;
    cyc(5);
    check("irq2", 32'(coreBodIrq), 32'h1);
    check("rst2", 32'(coreBodResetReq), 32'h0);
    coreBodIrqMask = 1'b0;
    cyc(3);
    check("irqMask", 32'(coreBodIrq), 32'h0);
    coreBodDetect = 1'b0;
    cyc(5);
    // Mode 0 is off: neither output moves.
    unl_wr(`OBC_BOD_OFS, 32'h00000045);
    coreBodIrqMask = 1'b1;
    coreBodDetect = 1'b1;
    cyc(5);
    check("off", 32'({coreBodResetReq, coreBodIrq}), 32'h0);
    // Reserved code 3 must neither reset nor interrupt.
    unl_wr(`OBC_BOD_OFS, 32'h00000345);
    cyc(5);
    check("rsvd", 32'({coreBodResetReq, coreBodIrq}), 32'h0);
    coreBodDetect = 1'b0;
    coreBodIrqMask = 1'b0;
    // Final-value bit freezes the bandgap register.
    unl_wr(`OBC_BG_OFS, 32'h80000003);
    rd("sfvSet", `OBC_BG_OFS, 32'h80010003);
    unl_wr(`OBC_BG_OFS, 32'h00000001);
    rd("sfvHold", `OBC_BG_OFS, 32'h80010003);
    // Brown-out warm reset skips the load; another cause reloads.
    fuseCoreBod = 10'h0ff;
    fuseBandgap = 3'h2;
    warm(1'b1);
    rd("skipBod", `OBC_BOD_OFS, 32'h00010345);
    rd("skipBg", `OBC_BG_OFS, 32'h80010003);
    warm(1'b0);
    rd("reBod", `OBC_BOD_OFS, 32'h0001007f);
    rd("reBg", `OBC_BG_OFS, 32'h00010002);
    // The I/O register obeys the same unlock and final-value guards.
    unl_wr(`OBC_IO_BROWNOUT_CONTROL_OFS, 32'h80000105);
    rd("ioWr", `OBC_IO_BROWNOUT_CONTROL_OFS, 32'h80010105);
    check("ioFld", 32'({ioBodCtrl, ioBodHyst, ioBodLevel}), 32'h085);
    unl_wr(`OBC_IO_BROWNOUT_CONTROL_OFS, 32'h0);
    rd("ioSfv", `OBC_IO_BROWNOUT_CONTROL_OFS, 32'h80010105);
    // Oscillator 0: enable, code 8 (4 ticks), auto gain, gain 2, crystal.
    unl_wr(`OBC_OSC0_OFS, 32'h0001080d);
    rd("osc0", `OBC_OSC0_OFS, 32'h0001080d);
    check("agc", 32'(oscAutoGain), 32'h1);
    check("gain", 32'(oscGain), 32'h2);
    check("xtal", 32'(oscCrystalEnable), 32'h1);
    check("pin0", 32'(oscOutPinFree), 32'h2);
    tick(3);
    check("rdy3", 32'(oscReady), 32'h0);
    tick(1);
    check("rdy4", 32'(oscReady), 32'h1);
    // Oscillator 1: code 0 waits nothing, external clock mode.
    unl_wr(`OBC_OSC0_OFS + `OBC_OSC_STRIDE, 32'h00010000);
    cyc(2);
    check("rdy0", 32'(oscReady), 32'h3);
    check("en1", 32'(oscEnable), 32'h3);
    check("ext1", 32'(oscCrystalEnable), 32'h1);
    check("pin1", 32'(oscOutPinFree), 32'h2);
    unl_wr(`OBC_OSC0_OFS, 32'h0);
    cyc(2);
    check("rdyOff", 32'(oscReady), 32'h2);
    check("agcOff", 32'(oscAutoGain), 32'h0);
    tally_and_finish();
  end
endmodule
